// ---- hdl/udi_pkg.sv ----
/*
  Constants for the USB device interrupt and endpoint reset block:
  register offsets, field positions, reset values and timing counts.
  Assumes a 40 MHz peripheral clock and a 32-bit APB register bus.
*/
`default_nettype none
package udi_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] UDI_OFS_ENABLE  = 12'h010;
  localparam logic [11:0] UDI_OFS_DISABLE = 12'h014;
  localparam logic [11:0] UDI_OFS_MASK    = 12'h018;
  localparam logic [11:0] UDI_OFS_STATUS  = 12'h01C;
  localparam logic [11:0] UDI_OFS_CLEAR   = 12'h020;
  localparam logic [11:0] UDI_OFS_EPRST   = 12'h028;
  localparam logic [11:0] UDI_OFS_STATE   = 12'h02C;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int UDI_NUM_EP       = 6;
  localparam int UDI_EP_FLAGS     = 5;
  localparam int UDI_IRQ_W        = 14;
  localparam int UDI_BIT_SUSPEND  = 8;
  localparam int UDI_BIT_RESUME   = 9;
  localparam int UDI_BIT_EXTERNAL_RESUME_FLAG   = 10;
  localparam int UDI_BIT_SOF      = 11;
  localparam int UDI_BIT_BUSRST   = 12;
  localparam int UDI_BIT_WAKEUP   = 13;
  localparam logic [13:0] UDI_EP_BITS    = 14'h003F;
  localparam logic [13:0] UDI_EVT_BITS   = 14'h3F00;
  localparam logic [13:0] UDI_MASK_BITS  = 14'h2F3F;
  localparam logic [13:0] UDI_MASK_RESET = 14'h1200;
  localparam logic [13:0] UDI_MASK_FIXED = 14'h1000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int UDI_CLK_HZ      = 40_000_000;
  localparam int UDI_SUSPEND_MS  = 3;
  localparam int UDI_SUSPEND_CYC = UDI_SUSPEND_MS * (UDI_CLK_HZ / 1000);
endpackage : udi_pkg
`default_nettype wire

// ---- hdl/udi_irq_ep_reset.sv ----
/*
  Interrupt status, mask and clear logic of a full-speed USB device port,
  with per-endpoint FIFO reset control, reached over APB.
  Assumes bus events arrive as one-cycle pulses synchronous to pclk and
  endpoint flags as levels from the endpoint control/status registers.
*/
`default_nettype none

// Functional notes
// - Mask readback shows each enabled source
// - Mask bit 12 always reads one
// - Resume mask enabled after reset
// - Endpoint status is OR of flags
// - Endpoint status clears only via flags
// - Suspend after 3ms bus idle
// - Resume signalling sets resume status
// - Every frame start sets bit 11
// - Bus reset end sets bit 12
// - Resume or reset sets wakeup bit
// - Clear register one clears event bit
// - Endpoint reset holds FIFO pointers zero
// - Endpoint reset returns toggle to DATA0
// - Endpoint reset leaves flags untouched
// - External resume has status, mask, clear
// - Enable register one sets mask bit
// - Disable register one clears mask bit
module udi_irq_ep_reset
  import udi_pkg::*;
#(
  parameter int SUSPEND_CYC = UDI_SUSPEND_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        bus_activity,
  input  wire logic        resume_seen,
  input  wire logic        ext_resume_seen,
  input  wire logic        frame_start_seen,
  input  wire logic        bus_reset_seen,
  input  wire logic        bus_reset_done,
  input  wire logic [29:0] ep_flag_bits,
  output logic             irq,
  output logic             suspended,
  output logic      [5:0]  ep_fifo_hold,
  output logic      [5:0]  ep_toggle_data0
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [13:0] mask_reg;
  logic [13:0] status_reg;
  logic [5:0]  ep_rst_reg;
  logic [16:0] idle_cnt_reg;
  logic        suspended_reg;
  logic        irq_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic [31:0] prdata_reg;
  logic [5:0]  ep_any;
  logic        wr_ok;
  logic [13:0] wdat;
  logic        suspend_evt;

  // Known register offset
  function automatic logic addr_hit(input logic [11:0] a);
    addr_hit = (a == UDI_OFS_ENABLE) || (a == UDI_OFS_DISABLE) ||
               (a == UDI_OFS_MASK) || (a == UDI_OFS_STATUS) ||
               (a == UDI_OFS_CLEAR) || (a == UDI_OFS_EPRST) ||
               (a == UDI_OFS_STATE);
  endfunction : addr_hit

  // ----------------------------------------------------------------
  // APB slave, one wait state
  // ----------------------------------------------------------------
  // Writes land on the edge that samples pready, never earlier
  assign wr_ok = psel && penable && pready_reg && pwrite && addr_hit(paddr);
  assign wdat  = pwdata[13:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= psel && penable && !pready_reg;
      pslverr_reg <= psel && penable && !pready_reg && !addr_hit(paddr);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel && penable && !pready_reg && !pwrite) begin
      case (paddr)
        UDI_OFS_MASK:   prdata_reg <= {18'h0, mask_reg};
        UDI_OFS_STATUS: prdata_reg <= {18'h0, status_reg};
        UDI_OFS_EPRST:  prdata_reg <= {26'h0, ep_rst_reg};
        UDI_OFS_STATE:  prdata_reg <= {31'h0, suspended_reg};
        default:        prdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Mask register
  // ----------------------------------------------------------------
  // resume enabled at reset; set and clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= UDI_MASK_RESET;
    end else if (wr_ok && paddr == UDI_OFS_ENABLE) begin
      mask_reg <= (mask_reg | (wdat & UDI_MASK_BITS)) | UDI_MASK_FIXED;
    end else if (wr_ok && paddr == UDI_OFS_DISABLE) begin
      mask_reg <= (mask_reg & ~(wdat & UDI_MASK_BITS)) | UDI_MASK_FIXED;
    end
  end

  // ----------------------------------------------------------------
  // Suspend detection
  // ----------------------------------------------------------------
  // Counter parks once suspended: one event per idle spell
  // idle timer
  assign suspend_evt = !bus_activity && !suspended_reg &&
                       (idle_cnt_reg == 17'(SUSPEND_CYC - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_cnt_reg  <= 17'h0;
      suspended_reg <= 1'b0;
    end else if (bus_activity) begin
      idle_cnt_reg  <= 17'h0;
      suspended_reg <= 1'b0;
    end else if (suspend_evt) begin
      suspended_reg <= 1'b1;
    end else if (!suspended_reg) begin
      idle_cnt_reg  <= idle_cnt_reg + 17'h1;
    end
  end

  // ----------------------------------------------------------------
  // Status register
  // ----------------------------------------------------------------
  // endpoint bits follow their flags only
  generate
    for (genvar e = 0; e < UDI_NUM_EP; e++) begin : g_ep
      assign ep_any[e] = |ep_flag_bits[e*UDI_EP_FLAGS +: UDI_EP_FLAGS];
    end
  endgenerate

  // Event bits: a set in the clearing cycle wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= 14'h0000;
    end else begin
      status_reg[5:0] <= ep_any;
      status_reg[7:6] <= 2'h0;
      status_reg[13:8] <= (status_reg[13:8] &
                           ~((wr_ok && paddr == UDI_OFS_CLEAR) ? wdat[13:8] : 6'h00))
                          | {bus_reset_seen || resume_seen,   // wakeup
                             bus_reset_done,                  // reset end
                             frame_start_seen,                // frame start
                             ext_resume_seen,                 // external resume
                             resume_seen,                     // resume
                             suspend_evt};                    // suspend
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(status_reg & mask_reg);
    end
  end

  // ----------------------------------------------------------------
  // Endpoint reset
  // ----------------------------------------------------------------
  // software drives both steps; no flag is touched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ep_rst_reg <= 6'h00;
    end else if (wr_ok && paddr == UDI_OFS_EPRST) begin
      ep_rst_reg <= pwdata[5:0];
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata    = prdata_reg;
  assign pready    = pready_reg;
  assign pslverr   = pslverr_reg;
  assign irq       = irq_reg;
  assign suspended = suspended_reg;
  assign ep_fifo_hold    = ep_rst_reg;
  assign ep_toggle_data0 = ep_rst_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_mask_fixed_one: assert property (@(posedge pclk) disable iff (!presetn)
    mask_reg[UDI_BIT_BUSRST])
    else $error("mask bit 12 not one");

  chk_mask_enable_set: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ok && paddr == UDI_OFS_ENABLE) |=> ((mask_reg & $past(wdat) & UDI_MASK_BITS)
                                            == ($past(wdat) & UDI_MASK_BITS)))
    else $error("enable write did not set mask");

  chk_mask_disable_clr: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ok && paddr == UDI_OFS_DISABLE) |=>
      ((mask_reg & $past(wdat) & UDI_MASK_BITS & ~UDI_MASK_FIXED) == 14'h0000))
    else $error("disable write did not clear mask");

  chk_ep_status_or: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 status_reg[5:0] == $past(ep_any))
    else $error("endpoint status not flag OR");

  chk_sof_sets_bit: assert property (@(posedge pclk) disable iff (!presetn)
    frame_start_seen |=> status_reg[UDI_BIT_SOF])
    else $error("frame start not flagged");

  chk_clear_event_bit: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ok && paddr == UDI_OFS_CLEAR && wdat[UDI_BIT_RESUME] && !resume_seen)
      |=> !status_reg[UDI_BIT_RESUME])
    else $error("clear did not clear resume");

  chk_wakeup_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    (status_reg[UDI_BIT_WAKEUP] && !(wr_ok && paddr == UDI_OFS_CLEAR))
      |=> status_reg[UDI_BIT_WAKEUP])
    else $error("wakeup bit lost");

  chk_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)
    |(status_reg & mask_reg) |=> irq)
    else $error("interrupt not raised");

  chk_suspend_timer: assert property (@(posedge pclk) disable iff (!presetn)
    suspend_evt |-> (idle_cnt_reg == 17'(SUSPEND_CYC - 1)) ##1 status_reg[UDI_BIT_SUSPEND])
    else $error("suspend flag timing wrong");

  chk_ep_hold_tracks: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ok && paddr == UDI_OFS_EPRST) |=> ep_fifo_hold == $past(pwdata[5:0]))
    else $error("endpoint hold not updated");

  chk_ep_toggle_tracks: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ok && paddr == UDI_OFS_EPRST)
      |=> ep_toggle_data0 == $past(pwdata[5:0]))
    else $error("endpoint toggle not updated");

  // ----------------------------------------------------------------
  // Checks: bus events and status
  // ----------------------------------------------------------------
  chk_ep_no_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ok && paddr == UDI_OFS_CLEAR && (|ep_any))
      |=> ((status_reg[5:0] & $past(ep_any)) == $past(ep_any)))
    else $error("clear register dropped endpoint bit");

  chk_resume_sets: assert property (@(posedge pclk) disable iff (!presetn)
    resume_seen
      |=> (status_reg[UDI_BIT_RESUME] && status_reg[UDI_BIT_WAKEUP]))
    else $error("resume not flagged");

  chk_ext_resume_sets: assert property (@(posedge pclk) disable iff (!presetn)
    ext_resume_seen
      |=> status_reg[UDI_BIT_EXTERNAL_RESUME_FLAG])
    else $error("external resume not flagged");

  chk_reset_end_sets: assert property (@(posedge pclk) disable iff (!presetn)
    bus_reset_done
      |=> status_reg[UDI_BIT_BUSRST])
    else $error("bus reset end not flagged");

  chk_reset_wakes: assert property (@(posedge pclk) disable iff (!presetn)
    bus_reset_seen
      |=> status_reg[UDI_BIT_WAKEUP])
    else $error("bus reset did not set wakeup");

  chk_suspend_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(suspended_reg)
      |-> status_reg[UDI_BIT_SUSPEND])
    else $error("suspend entered without flag");

  chk_activity_wakes: assert property (@(posedge pclk) disable iff (!presetn)
    bus_activity
      |=> !suspended_reg)
    else $error("suspend kept through bus activity");

  chk_irq_drops: assert property (@(posedge pclk) disable iff (!presetn)
    !(|(status_reg & mask_reg))
      |=> !irq)
    else $error("interrupt high with nothing pending");

  // ----------------------------------------------------------------
  // Checks: register bus and mask
  // ----------------------------------------------------------------
  chk_mask_after_reset: assert property (@(posedge pclk)
    $rose(presetn)
      |-> (mask_reg == UDI_MASK_RESET))
    else $error("mask reset value wrong");

  chk_enable_zero_keeps: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ok && paddr == UDI_OFS_ENABLE && wdat == 14'h0000)
      |=> $stable(mask_reg))
    else $error("enable write of zero changed mask");

  chk_disable_zero_keeps: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_ok && paddr == UDI_OFS_DISABLE && wdat == 14'h0000)
      |=> $stable(mask_reg))
    else $error("disable write of zero changed mask");

  chk_ready_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
    pready
      |=> !pready)
    else $error("ready held longer than one cycle");

  chk_error_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr
      |-> pready)
    else $error("error raised without ready");

  chk_error_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pready && !addr_hit(paddr))
      |-> pslverr)
    else $error("unmapped access not refused");

endmodule : udi_irq_ep_reset
`default_nettype wire

// ---- dv/udi_host_model.sv ----
/*
  Host side stand-in: turns bench requests into bus event pulses.
  Assumes requests change just after pclk rises; bit 5 is a level.
*/
`default_nettype none
module udi_host_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [5:0] ev_req,
  output logic            resume_seen,
  output logic            ext_resume_seen,
  output logic            frame_start_seen,
  output logic            bus_reset_seen,
  output logic            bus_reset_done,
  output logic            bus_activity
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {bus_activity, bus_reset_done, bus_reset_seen, frame_start_seen,
       ext_resume_seen, resume_seen} <= 6'h20;
    end else begin
      {bus_activity, bus_reset_done, bus_reset_seen, frame_start_seen,
       ext_resume_seen, resume_seen} <= ev_req;
    end
  end
endmodule : udi_host_model
`default_nettype wire

// ---- dv/udi_irq_ep_reset_bench.sv ----
/*
  Self-checking bench: APB master tasks, host model, one task a scenario.
  Assumes the one-wait-state APB slave and SUSPEND_CYC shortened to 20.
*/
`default_nettype none
module udi_irq_ep_reset_bench import udi_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, pready, pslverr, irq, suspended, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [29:0] ep_flag_bits = 30'h0;
  logic [5:0]  ev_req = 6'h20, ep_fifo_hold, ep_toggle_data0;
  wire logic   rs, ers, fss, brs, brd, act;
  int          num_errors = 0, n_checks = 0, cyc = 0;

  udi_host_model host_u (.pclk(pclk), .presetn(presetn), .ev_req(ev_req),
    .resume_seen(rs), .ext_resume_seen(ers), .frame_start_seen(fss),
    .bus_reset_seen(brs), .bus_reset_done(brd), .bus_activity(act));
  udi_irq_ep_reset #(.SUSPEND_CYC(20)) dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus_activity(act), .resume_seen(rs), .ext_resume_seen(ers),
    .frame_start_seen(fss), .bus_reset_seen(brs), .bus_reset_done(brd),
    .ep_flag_bits(ep_flag_bits), .irq(irq), .suspended(suspended),
    .ep_fifo_hold(ep_fifo_hold), .ep_toggle_data0(ep_toggle_data0));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // No fixed latency assumed; the timeout ends a hung wait
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdchk
  task automatic pulse(input logic [5:0] m);
    ev_req <= m | 6'h20;
    @(posedge pclk);
    ev_req <= 6'h20;
    repeat (3) @(posedge pclk);
  endtask : pulse
  task automatic conclude;
    $display("errors=%0d checks=%0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_events;
    logic [31:0] e [5] = '{32'h2200, 32'h0400, 32'h0800, 32'h2000, 32'h1000};
    for (int i = 0; i < 5; i++) begin
      pulse(6'h01 << i);
      rdchk(UDI_OFS_STATUS, e[i]);
      chk({31'h0, irq}, {31'h0, |(e[i] & 32'h1200)});
      apb(1'b1, UDI_OFS_CLEAR, 32'h0);
      rdchk(UDI_OFS_STATUS, e[i]);
      apb(1'b1, UDI_OFS_CLEAR, e[i]);
      rdchk(UDI_OFS_STATUS, 32'h0);
      chk({31'h0, irq}, 32'h0);
    end
  endtask : t_events
  task automatic t_mask;
    apb(1'b1, UDI_OFS_ENABLE, 32'hFFFF_FFFF);
    rdchk(UDI_OFS_MASK, 32'h3F3F);
    apb(1'b1, UDI_OFS_DISABLE, 32'h0000_0600);
    rdchk(UDI_OFS_MASK, 32'h393F);
    apb(1'b1, UDI_OFS_ENABLE, 32'h0);
    apb(1'b1, UDI_OFS_DISABLE, 32'h0);
    rdchk(UDI_OFS_MASK, 32'h393F);
    apb(1'b1, UDI_OFS_DISABLE, 32'hFFFF_FFFF);
    rdchk(UDI_OFS_MASK, 32'h1000);
    apb(1'b0, 12'h030, 32'h0);
    chk({31'h0, err}, 32'h1);
    pulse(6'h04);
    rdchk(UDI_OFS_STATUS, 32'h0800);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, UDI_OFS_ENABLE, 32'h0000_0800);
    // Interrupt follows the mask one edge after the write
    @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, UDI_OFS_CLEAR, 32'h0000_0800);
  endtask : t_mask
  task automatic t_suspend;
    ev_req <= 6'h00;
    // Idle reaches the design one edge late; 20 idle edges then suspend
    repeat (21) @(posedge pclk);
    chk({31'h0, suspended}, 32'h0);
    @(posedge pclk);
    chk({31'h0, suspended}, 32'h1);
    rdchk(UDI_OFS_STATUS, 32'h0100);
    rdchk(UDI_OFS_STATE, 32'h1);
    ev_req <= 6'h20;
    repeat (3) @(posedge pclk);
    chk({31'h0, suspended}, 32'h0);
    rdchk(UDI_OFS_STATE, 32'h0);
    apb(1'b1, UDI_OFS_CLEAR, 32'h0000_0100);
  endtask : t_suspend
  task automatic t_endpoints;
    apb(1'b1, UDI_OFS_ENABLE, 32'h0000_003F);
    for (int e = 0; e < 6; e++) begin
      ep_flag_bits <= 30'h1 << (5 * e + e % 5);
      repeat (3) @(posedge pclk);
      rdchk(UDI_OFS_STATUS, 32'h1 << e);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, UDI_OFS_CLEAR, 32'h0000_003F);
      rdchk(UDI_OFS_STATUS, 32'h1 << e);
      ep_flag_bits <= 30'h0;
      repeat (3) @(posedge pclk);
      rdchk(UDI_OFS_STATUS, 32'h0);
      chk({31'h0, irq}, 32'h0);
    end
  endtask : t_endpoints
  task automatic t_ep_reset;
    ep_flag_bits <= 30'h1;
    apb(1'b1, UDI_OFS_EPRST, 32'h0000_002A);
    rdchk(UDI_OFS_EPRST, 32'h2A);
    chk({26'h0, ep_fifo_hold}, 32'h2A);
    chk({26'h0, ep_toggle_data0}, 32'h2A);
    rdchk(UDI_OFS_STATUS, 32'h1);
    apb(1'b1, UDI_OFS_EPRST, 32'h0);
    chk({26'h0, ep_fifo_hold}, 32'h0);
    chk({26'h0, ep_toggle_data0}, 32'h0);
    ep_flag_bits <= 30'h0;
  endtask : t_ep_reset

  initial begin
    forever #12.5 pclk = ~pclk;
  end
  // Ceiling well above the roughly 400 cycles the scenarios need
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      conclude();
    end
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(UDI_OFS_MASK, 32'h1200);
    rdchk(UDI_OFS_STATUS, 32'h0);
    t_events();
    t_mask();
    t_suspend();
    t_endpoints();
    t_ep_reset();
    conclude();
  end
endmodule : udi_irq_ep_reset_bench
`default_nettype wire
